// ===== rtl/psw_pkg.sv
// shared constants, timing tables and host register map for the watchdog pair
package psw_pkg;
  // clock and timebase
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
  localparam int STROBE_MIN_NS = 100;
  localparam int STROBE_MIN_CYCLES = (STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int US_PER_MS = 1000;
  localparam int US_PER_S = 1000000;
  localparam int TICKS_PER_US = 1000 / TICK_NS > 0 ? 1000 / TICK_NS : 1;
  // settle interval and fault pulse widths, in timebase ticks
  localparam int SETTLE_US = 300;
  localparam int SETTLE_TICKS = SETTLE_US * TICKS_PER_US;
  localparam int PULSE_OD_MS = 100;
  localparam int PULSE_OD_TICKS = PULSE_OD_MS * US_PER_MS * TICKS_PER_US;
  localparam int PULSE_PP_MS = 1;
  localparam int PULSE_PP_TICKS = PULSE_PP_MS * US_PER_MS * TICKS_PER_US;
  // timer width covers the longest period, 60 s in microseconds
  localparam int CNT_W = 26;
  typedef logic [CNT_W-1:0] psw_cnt_t;
  localparam psw_cnt_t T_30US = 26'd30;
  localparam psw_cnt_t T_200US = 26'd200;
  localparam psw_cnt_t T_1MS = psw_cnt_t'(1 * US_PER_MS);
  localparam psw_cnt_t T_3MS = psw_cnt_t'(3 * US_PER_MS);
  localparam psw_cnt_t T_10MS = psw_cnt_t'(10 * US_PER_MS);
  localparam psw_cnt_t T_30MS = psw_cnt_t'(30 * US_PER_MS);
  localparam psw_cnt_t T_100MS = psw_cnt_t'(100 * US_PER_MS);
  localparam psw_cnt_t T_300MS = psw_cnt_t'(300 * US_PER_MS);
  localparam psw_cnt_t T_1S = psw_cnt_t'(1 * US_PER_S);
  localparam psw_cnt_t T_3S = psw_cnt_t'(3 * US_PER_S);
  localparam psw_cnt_t T_10S = psw_cnt_t'(10 * US_PER_S);
  localparam psw_cnt_t T_60S = psw_cnt_t'(60 * US_PER_S);
  // select codes and variants
  localparam logic [2:0] SEL_DISABLE = 3'h3;
  localparam logic [2:0] SEL_FIRST_A = 3'h5;
  localparam logic [2:0] SEL_FIRST_B = 3'h6;
  localparam int VAR_EQUAL = 0;
  localparam int VAR_FIXED = 1;
  localparam int VAR_FLEX = 2;
  // host register map
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam int CTRL_STROBE = 0;
  localparam int CTRL_SEL_LSB = 1;
  localparam int STAT_LIVE = 0;
  localparam int STAT_STICKY = 1;
  localparam int STAT_BUSY = 2;
  localparam int STAT_SEL_LSB = 4;
  localparam int HOST_HOLD_CYCLES = 2 * STROBE_MIN_CYCLES + 4;

  ////////////////////////////////////////////////////////////////////////////
  // first-edge codes exist only on the flexible variant
  function automatic logic is_first_edge(input int variant, input logic [2:0] sel);
    is_first_edge = (variant == VAR_FLEX) && (sel == SEL_FIRST_A || sel == SEL_FIRST_B);
  endfunction : is_first_edge

  // timeout period in microseconds for a variant and code
  function automatic psw_cnt_t timeout_us(input int variant, input logic [2:0] sel);
    psw_cnt_t t;
    t = T_1MS;
    if (variant == VAR_FLEX) begin
      case (sel)
        3'h0: t = T_3MS;
        3'h1: t = T_3S;
        3'h2: t = T_1S;
        3'h4: t = T_30US;
        3'h5: t = T_1S;
        default: t = T_10S;
      endcase
    end else if (variant == VAR_FIXED) begin
      case (sel)
        3'h0: t = T_1MS;
        3'h1: t = T_3MS;
        3'h2: t = T_10MS;
        3'h4: t = T_100MS;
        3'h5: t = T_300MS;
        3'h6: t = T_3S;
        default: t = T_60S;
      endcase
    end else begin
      case (sel)
        3'h0: t = T_1MS;
        3'h1: t = T_10MS;
        3'h2: t = T_30MS;
        3'h4: t = T_100MS;
        3'h5: t = T_1S;
        3'h6: t = T_10S;
        default: t = T_60S;
      endcase
    end
    timeout_us = t;
  endfunction : timeout_us

  // startup delay in microseconds; first-edge codes are handled separately
  function automatic psw_cnt_t startup_us(input int variant, input logic [2:0] sel);
    psw_cnt_t t;
    t = timeout_us(variant, sel);
    if (variant == VAR_FIXED) begin
      t = T_60S;
    end else if (variant == VAR_FLEX) begin
      case (sel)
        3'h0: t = T_3MS;
        3'h1: t = T_3S;
        3'h4: t = T_200US;
        default: t = T_60S;
      endcase
    end
    startup_us = t;
  endfunction : startup_us
endpackage : psw_pkg

// ===== rtl/psw_if.sv
// link between watchdog device and host: strobe, selects and fault pin
`timescale 1ns/1ps
interface psw_if;
  logic strobe_in;
  logic timing_sel_0;
  logic timing_sel_1;
  logic timing_sel_2;
  logic fault_pulse_n;
  logic fault_oe;
  logic fault_level;

  // an undriven open-drain fault line is pulled high
  assign fault_level = fault_oe ? fault_pulse_n : 1'b1;

  modport dev (
    input strobe_in,
    input timing_sel_0,
    input timing_sel_1,
    input timing_sel_2,
    output fault_pulse_n,
    output fault_oe
  );

  modport host (
    output strobe_in,
    output timing_sel_0,
    output timing_sel_1,
    output timing_sel_2,
    input fault_level
  );
endinterface : psw_if

// ===== rtl/psw_device.sv
// watchdog supervisor: strobe qualification, select handling and fault pulse
//
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
module psw_device #(
  parameter int VARIANT = psw_pkg::VAR_EQUAL,         // timing table variant
  parameter bit PUSH_PULL = 1'b0,                     // 1 push-pull, 0 open drain
  parameter int TICK_DIV = psw_pkg::TICK_CYCLES,      // clocks per timebase tick
  parameter int SETTLE_TICKS = psw_pkg::SETTLE_TICKS, // settle interval
  parameter int PULSE_OD_TICKS = psw_pkg::PULSE_OD_TICKS, // open-drain pulse
  parameter int PULSE_PP_TICKS = psw_pkg::PULSE_PP_TICKS  // push-pull pulse
) (
  input wire logic pclk,    // 100 MHz clock
  input wire logic presetn, // async reset, acts as power-up
  psw_if.dev link,          // strobe, selects and fault pin
  output logic wd_running,  // timeout countdown armed
  output logic wd_disabled  // disable code in force
);
  import psw_pkg::*;

  typedef enum logic [2:0] {
    ST_SETTLE,
    ST_STARTUP,
    ST_WAIT_EDGE,
    ST_RUN,
    ST_FAULT,
    ST_DISABLED
  } psw_state_e;

  psw_state_e state;
  logic [15:0] tick_cnt;
  logic tick;
  logic strobe_meta;
  logic strobe_sync;
  logic [2:0] sel_meta;
  logic [2:0] sel_sync;
  logic strobe_level;
  logic [7:0] qual_cnt;
  logic strobe_evt;
  logic [2:0] applied_sel;
  psw_cnt_t cnt;
  psw_cnt_t limit;
  logic expire;
  logic sel_changed;

  ////////////////////////////////////////////////////////////////////////////
  // timebase: one-cycle tick every TICK_DIV clocks; periods are exact only to
  // one tick because a cleared timer does not realign the divider
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt <= '0;
      tick <= 1'b0;
    end else if (tick_cnt == 16'(TICK_DIV - 1)) begin
      tick_cnt <= '0;
      tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 16'h0001;
      tick <= 1'b0;
    end
  end

  // two-stage synchronisers; first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strobe_meta <= 1'b0;
      strobe_sync <= 1'b0;
      sel_meta <= 3'h0;
      sel_sync <= 3'h0;
    end else begin
      strobe_meta <= link.strobe_in;
      strobe_sync <= strobe_meta;
      sel_meta <= {link.timing_sel_2, link.timing_sel_1, link.timing_sel_0};
      sel_sync <= sel_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // a new level counts only once it has held for the minimum pulse width;
  // shorter pulses never reach the timer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strobe_level <= 1'b0;
      qual_cnt <= '0;
      strobe_evt <= 1'b0;
    end else if (strobe_sync == strobe_level) begin
      qual_cnt <= '0;
      strobe_evt <= 1'b0;
    end else if (qual_cnt == 8'(STROBE_MIN_CYCLES - 1)) begin
      strobe_level <= strobe_sync;
      qual_cnt <= '0;
      strobe_evt <= 1'b1;
    end else begin
      qual_cnt <= qual_cnt + 8'h01;
      strobe_evt <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // period being timed in the current state
  always_comb begin
    limit = psw_cnt_t'(SETTLE_TICKS);
    case (state)
      ST_STARTUP: limit = startup_us(VARIANT, applied_sel);
      ST_RUN: limit = timeout_us(VARIANT, applied_sel);
      ST_FAULT: limit = PUSH_PULL ? psw_cnt_t'(PULSE_PP_TICKS)
                                  : psw_cnt_t'(PULSE_OD_TICKS);
      default: limit = psw_cnt_t'(SETTLE_TICKS);
    endcase
  end

  assign expire = tick && (cnt >= limit - psw_cnt_t'(1));
  // a change seen during the pulse waits until the pulse is over
  assign sel_changed = (sel_sync != applied_sel) && (state != ST_FAULT);

  ////////////////////////////////////////////////////////////////////////////
  // main sequencer; strobe events are looked at only in wait-edge and run
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_SETTLE;
      applied_sel <= 3'h0;
      cnt <= '0;
    end else if (sel_changed) begin
      applied_sel <= sel_sync;
      state <= ST_SETTLE;
      cnt <= '0;
    end else begin
      case (state)
        ST_SETTLE: begin
          if (expire) begin
            cnt <= '0;
            if (applied_sel == SEL_DISABLE) begin
              state <= ST_DISABLED;
            end else if (is_first_edge(VARIANT, applied_sel)) begin
              state <= ST_WAIT_EDGE;
            end else begin
              state <= ST_STARTUP;
            end
          end else if (tick) begin
            cnt <= cnt + psw_cnt_t'(1);
          end
        end
        ST_STARTUP: begin
          if (expire) begin
            state <= ST_RUN;
            cnt <= '0;
          end else if (tick) begin
            cnt <= cnt + psw_cnt_t'(1);
          end
        end
        ST_WAIT_EDGE: begin
          // no deadline here: only a qualified edge ends startup
          if (strobe_evt) begin
            state <= ST_RUN;
            cnt <= '0;
          end
        end
        ST_RUN: begin
          if (strobe_evt) begin
            cnt <= '0;
          end else if (expire) begin
            state <= ST_FAULT;
            cnt <= '0;
          end else if (tick) begin
            cnt <= cnt + psw_cnt_t'(1);
          end
        end
        ST_FAULT: begin
          if (expire) begin
            state <= ST_RUN;
            cnt <= '0;
          end else if (tick) begin
            cnt <= cnt + psw_cnt_t'(1);
          end
        end
        ST_DISABLED: begin
          cnt <= '0;
        end
        default: begin
          state <= ST_SETTLE;
          cnt <= '0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fault pin and status, all registered; low only in the fault state, so
  // disable, settle and startup keep the line high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link.fault_pulse_n <= 1'b1;
      link.fault_oe <= PUSH_PULL;
      wd_running <= 1'b0;
      wd_disabled <= 1'b0;
    end else begin
      link.fault_pulse_n <= (state != ST_FAULT);
      link.fault_oe <= PUSH_PULL | (state == ST_FAULT);
      wd_running <= (state == ST_RUN) && !sel_changed;
      wd_disabled <= (state == ST_DISABLED);
    end
  end
endmodule : psw_device

// ===== rtl/psw_host.sv
// host end: apb-controlled strobe and select driver watching the fault line
`timescale 1ns/1ps
module psw_host #(
  parameter int HOLD_CYCLES = psw_pkg::HOST_HOLD_CYCLES // wait between steps
) (
  input wire logic pclk,           // 100 MHz clock
  input wire logic presetn,        // async reset, active low
  input wire logic [11:0] paddr,   // apb address
  input wire logic psel,           // apb select
  input wire logic penable,        // apb enable
  input wire logic pwrite,         // apb direction
  input wire logic [31:0] pwdata,  // apb write data
  output logic [31:0] prdata,      // apb read data
  output logic pready,             // apb ready
  output logic pslverr,            // apb error, unmapped address
  psw_if.host link                 // strobe, selects and fault pin
);
  import psw_pkg::*;

  typedef enum logic [1:0] {
    HS_IDLE,
    HS_PRE,
    HS_DIS
  } psw_host_e;

  psw_host_e state;
  logic strobe_q;
  logic [2:0] target_sel;
  logic [2:0] drive_sel;
  logic [7:0] hold_cnt;
  logic fault_live;
  logic fault_sticky;
  logic wr_ctrl;
  logic wr_stat;
  logic [2:0] new_sel;
  logic hold_done;

  assign wr_ctrl = psel && penable && pwrite && (paddr == REG_CTRL);
  assign wr_stat = psel && penable && pwrite && (paddr == REG_STATUS);
  assign new_sel = pwdata[CTRL_SEL_LSB +: 3];
  assign hold_done = (hold_cnt == 8'(HOLD_CYCLES - 1));

  ////////////////////////////////////////////////////////////////////////////
  // select change sequence: toggle strobe, wait, pass through disable when
  // heading for a first-edge code, then drive the target code
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= HS_IDLE;
      strobe_q <= 1'b0;
      target_sel <= 3'h0;
      drive_sel <= 3'h0;
      hold_cnt <= '0;
    end else begin
      case (state)
        HS_IDLE: begin
          hold_cnt <= '0;
          if (wr_ctrl && new_sel != target_sel) begin
            strobe_q <= ~strobe_q;
            target_sel <= new_sel;
            state <= HS_PRE;
          end else if (wr_ctrl) begin
            strobe_q <= pwdata[CTRL_STROBE];
          end
        end
        HS_PRE: begin
          if (hold_done) begin
            hold_cnt <= '0;
            if ((target_sel == SEL_FIRST_A || target_sel == SEL_FIRST_B) &&
                drive_sel != SEL_DISABLE) begin
              drive_sel <= SEL_DISABLE;
              state <= HS_DIS;
            end else begin
              drive_sel <= target_sel;
              state <= HS_IDLE;
            end
          end else begin
            hold_cnt <= hold_cnt + 8'h01;
          end
        end
        HS_DIS: begin
          // a pending pulse must end before disable takes hold
          if (!fault_live) begin
            hold_cnt <= '0;
          end else if (hold_done) begin
            hold_cnt <= '0;
            drive_sel <= target_sel;
            state <= HS_IDLE;
          end else begin
            hold_cnt <= hold_cnt + 8'h01;
          end
        end
        default: begin
          state <= HS_IDLE;
          hold_cnt <= '0;
        end
      endcase
    end
  end

  // link pins straight from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link.strobe_in <= 1'b0;
      link.timing_sel_0 <= 1'b0;
      link.timing_sel_1 <= 1'b0;
      link.timing_sel_2 <= 1'b0;
    end else begin
      link.strobe_in <= strobe_q;
      link.timing_sel_0 <= drive_sel[0];
      link.timing_sel_1 <= drive_sel[1];
      link.timing_sel_2 <= drive_sel[2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fault monitor; a new fault beats a software clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_live <= 1'b1;
      fault_sticky <= 1'b0;
    end else begin
      fault_live <= link.fault_level;
      if (!fault_live) begin
        fault_sticky <= 1'b1;
      end else if (wr_stat && pwdata[STAT_STICKY]) begin
        fault_sticky <= 1'b0;
      end
    end
  end

  // apb slave: zero wait states, read data prepared in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (psel && !penable) begin
        pslverr <= (paddr != REG_CTRL) && (paddr != REG_STATUS);
        prdata <= '0;
        if (paddr == REG_CTRL) begin
          prdata[CTRL_STROBE] <= strobe_q;
          prdata[CTRL_SEL_LSB +: 3] <= target_sel;
        end else if (paddr == REG_STATUS) begin
          prdata[STAT_LIVE] <= fault_live;
          prdata[STAT_STICKY] <= fault_sticky;
          prdata[STAT_BUSY] <= (state != HS_IDLE);
          prdata[STAT_SEL_LSB +: 3] <= drive_sel;
        end
      end
    end
  end
endmodule : psw_host

// ===== verification/psw_link_sva.sv
// checker for the watchdog link between device and host
`timescale 1ns/1ps
module psw_link_sva #(
  parameter int TICK_DIV = 2, // clocks per tick
  parameter int PULSE_TICKS = 40, // fault pulse width
  parameter int TO_TICKS = 30 // shortest timeout in use
) (
  input wire logic pclk, // clock
  input wire logic presetn, // reset, active low
  input wire logic strobe_in, // strobe pin
  input wire logic timing_sel_0, // select bit 0
  input wire logic timing_sel_1, // select bit 1
  input wire logic timing_sel_2, // select bit 2
  input wire logic fault_pulse_n, // fault output
  input wire logic fault_oe, // fault driver on
  input wire logic wd_running, // countdown armed
  input wire logic wd_disabled // disable in force
);
  localparam int PW_LO = (PULSE_TICKS - 1) * TICK_DIV;
  localparam int PW_HI = (PULSE_TICKS + 1) * TICK_DIV;
  localparam int TO_LO = (TO_TICKS - 1) * TICK_DIV;
  logic [2:0] sel;
  logic [2:0] sel_q;
  logic strobe_q;
  logic [15:0] quiet;
  logic [15:0] lo_cnt;
  logic [3:0] run_age;
  logic sel_in_fault;
  assign sel = {timing_sel_2, timing_sel_1, timing_sel_0};
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  //////////////////////////////////////////////////////////////////////////
  // last pin values, for change detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_q <= 3'h0;
      strobe_q <= 1'b0;
    end else begin
      sel_q <= sel;
      strobe_q <= strobe_in;
    end
  end
  // cycles since the strobe moved; saturates so long idles never wrap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) quiet <= 16'h0;
    else if (strobe_in != strobe_q) quiet <= 16'h0;
    else if (quiet != 16'hffff) quiet <= quiet + 16'h1;
  end
  // length of the current low pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) lo_cnt <= 16'h0;
    else if (fault_pulse_n) lo_cnt <= 16'h0;
    else lo_cnt <= lo_cnt + 16'h1;
  end
  // cycles since the countdown was last armed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) run_age <= 4'hf;
    else if (wd_running) run_age <= 4'h0;
    else if (run_age != 4'hf) run_age <= run_age + 4'h1;
  end
  // select moved while the pulse was low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) sel_in_fault <= 1'b0;
    else if (fault_pulse_n) sel_in_fault <= 1'b0;
    else if (sel != sel_q) sel_in_fault <= 1'b1;
  end
  //////////////////////////////////////////////////////////////////////////
  chk_pulse_width: assert property ($rose(fault_pulse_n) |->
    lo_cnt >= PW_LO && lo_cnt <= PW_HI) else $error("fault pulse width off");
  chk_od_drive: assert property (fault_oe == !fault_pulse_n)
    else $error("open drain enable wrong");
  chk_dis_high: assert property (wd_disabled |-> fault_pulse_n)
    else $error("fault low while disabled");
  chk_dis_code: assert property ($rose(wd_disabled) |-> sel == 3'h3)
    else $error("disabled under wrong code");
  chk_fault_from_run: assert property ($fell(fault_pulse_n) |-> run_age < 4'h4)
    else $error("fault outside run state");
  chk_no_early: assert property ($fell(fault_pulse_n) |-> quiet >= TO_LO)
    else $error("fault before timeout");
  chk_sel_stop: assert property ($changed(sel) && wd_running |-> ##[1:4] !wd_running)
    else $error("select change not applied");
  chk_settle_mask: assert property ($changed(sel) |-> ##4 !wd_running [*6])
    else $error("run during settle");
  chk_restart_run: assert property ($rose(fault_pulse_n) && !sel_in_fault |->
    ##[0:4] wd_running) else $error("no restart after pulse");
  chk_fault_change: assert property ($rose(fault_pulse_n) && sel_in_fault |->
    !wd_running [*8]) else $error("new setting skipped settle");
  cover property ($rose(fault_pulse_n) && sel_in_fault);
  cover property ($rose(wd_disabled));
  cover property ($fell(fault_pulse_n));
endmodule : psw_link_sva

// ===== verification/pin_selectable_watchdog_tb.sv
// self-checking bench joining the watchdog device and its host end
`timescale 1ns/1ps
module pin_selectable_watchdog_tb;
  import psw_pkg::*;
  localparam int DIV = 2; // shortened timebase
  localparam int SETTLE = 5;
  localparam int PW = 40;
  localparam int TO4 = 30; // code 100 timeout in ticks
  localparam int ST4 = (SETTLE + 200) * DIV; // settle plus code 100 startup
  localparam int ST0 = (SETTLE + 3000) * DIV; // settle plus code 000 startup
  logic pclk;
  logic presetn;
  logic [11:0] paddr;
  logic psel;
  logic penable;
  logic pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic wd_running;
  logic wd_disabled;
  logic run2;
  logic [2:0] ctl_sel;
  logic [31:0] r;
  logic e;
  int bad_count;
  int n_tests;
  int n;
  int k;
  psw_if link ();
  psw_if link2 ();
  // open-drain device driven by the host, then a push-pull device strobed directly by the bench
  psw_device #(.VARIANT(VAR_FLEX), .PUSH_PULL(1'b0), .TICK_DIV(DIV), .SETTLE_TICKS(SETTLE),
    .PULSE_OD_TICKS(PW), .PULSE_PP_TICKS(PW)) psw_device_i (.pclk(pclk), .presetn(presetn),
    .link(link), .wd_running(wd_running), .wd_disabled(wd_disabled));
  psw_device #(.VARIANT(VAR_FLEX), .PUSH_PULL(1'b1), .TICK_DIV(DIV), .SETTLE_TICKS(SETTLE),
    .PULSE_OD_TICKS(PW), .PULSE_PP_TICKS(PW / 2)) psw_device_i2 (.pclk(pclk), .presetn(presetn),
    .link(link2), .wd_running(run2), .wd_disabled());
  psw_host #(.HOLD_CYCLES(HOST_HOLD_CYCLES)) psw_host_i (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
  psw_link_sva #(.TICK_DIV(DIV), .PULSE_TICKS(PW), .TO_TICKS(TO4)) psw_link_sva_i (
    .pclk(pclk), .presetn(presetn), .strobe_in(link.strobe_in),
    .timing_sel_0(link.timing_sel_0), .timing_sel_1(link.timing_sel_1),
    .timing_sel_2(link.timing_sel_2), .fault_pulse_n(link.fault_pulse_n),
    .fault_oe(link.fault_oe), .wd_running(wd_running), .wd_disabled(wd_disabled));
  //////////////////////////////////////////////////////////////////////////
  // clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  function automatic logic inr(input int v, input int lo, input int hi);
    inr = v >= lo && v <= hi;
  endfunction : inr
  function automatic logic sig(input int w);
    case (w)
      0: sig = wd_running;
      1: sig = link.fault_level;
      2: sig = wd_disabled;
      default: sig = link2.fault_level;
    endcase
  endfunction : sig
  // bounded wait; running out ends the run as a mismatch
  task wait_for(input int w, input logic v, input int bound, output int cnt);
    cnt = 0;
    while (sig(w) !== v && cnt < bound) begin
      @(negedge pclk);
      cnt++;
    end
    if (sig(w) !== v) begin
      check(32'h0, 32'h1);
      tally_and_finish();
    end
  endtask : wait_for
  // one apb transfer; the wait for pready is bounded
  task apb(input logic [11:0] a, input logic w, input logic [31:0] d, output logic [31:0] rd_v,
    output logic err);
    int c;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    c = 0;
    do begin
      @(posedge pclk);
      c++;
    end while (pready !== 1'b1 && c < 20);
    rd_v = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      check(32'h0, 32'h1);
      tally_and_finish();
    end
  endtask : apb
  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] x;
    logic y;
    apb(a, 1'b1, d, x, y);
  endtask : wr
  task setsel(input logic [2:0] s);
    ctl_sel = s;
    wr(REG_CTRL, {28'h0, s, link.strobe_in});
  endtask : setsel
  task tog;
    wr(REG_CTRL, {28'h0, ctl_sel, ~link.strobe_in});
  endtask : tog
  // direct strobe pulses on the second link, counting fault lows
  task pulses(input int hi, input int lo, input int cnt, output int lows);
    lows = 0;
    repeat (cnt) begin
      @(posedge pclk);
      link2.strobe_in <= 1'b1;
      repeat (hi) begin
        @(negedge pclk);
        lows += (link2.fault_level !== 1'b1);
      end
      @(posedge pclk);
      link2.strobe_in <= 1'b0;
      repeat (lo) begin
        @(negedge pclk);
        lows += (link2.fault_level !== 1'b1);
      end
    end
  endtask : pulses
  //////////////////////////////////////////////////////////////////////////
  task t_reset;
    wait_for(0, 1'b1, ST0 + 40, n);
    check(inr(n, ST0 - 4, ST0 + 10), 1'b1);
    apb(REG_STATUS, 1'b0, 32'h0, r, e);
    check(r[2:1], 2'h0);
    apb(12'h010, 1'b0, 32'h0, r, e);
    check({e, r[30:0]}, {1'b1, 31'h0});
    $display("test reset done");
  endtask : t_reset
  task t_sel;
    setsel(3'h4);
    wait_for(0, 1'b0, 60, n);
    wait_for(0, 1'b1, ST4 + 20, n);
    check(inr(n, ST4 - 4, ST4 + 6), 1'b1);
    $display("test select done");
  endtask : t_sel
  task t_timeout;
    wait_for(1, 1'b0, TO4 * DIV + 10, n);
    check(inr(n, TO4 * DIV - 6, TO4 * DIV + 6), 1'b1);
    wait_for(1, 1'b1, PW * DIV + 10, n);
    check(inr(n, PW * DIV - 3, PW * DIV + 3), 1'b1);
    wait_for(1, 1'b0, TO4 * DIV + 10, n);
    check(inr(n, TO4 * DIV - 4, TO4 * DIV + 6), 1'b1);
    apb(REG_STATUS, 1'b0, 32'h0, r, e);
    check(r[1:0], 2'h2);
    wait_for(1, 1'b1, PW * DIV + 10, n);
    wr(REG_STATUS, 32'h2);
    apb(REG_STATUS, 1'b0, 32'h0, r, e);
    check(r[1:0], 2'h1);
    $display("test timeout done");
  endtask : t_timeout
  task t_alive;
    k = 0;
    repeat (10) begin
      tog();
      repeat (28) begin
        @(negedge pclk);
        if (link.fault_level !== 1'b1) k++;
      end
    end
    check(k, 0);
    $display("test alive done");
  endtask : t_alive
  task t_change_in_fault;
    wait_for(1, 1'b0, 100, n);
    setsel(3'h0);
    wait_for(1, 1'b1, PW * DIV + 8, n);
    check(inr(n, PW * DIV - 12, PW * DIV), 1'b1);
    wait_for(0, 1'b1, ST0 + 40, n);
    check(inr(n, ST0 - 6, ST0 + 8), 1'b1);
    $display("test change in fault done");
  endtask : t_change_in_fault
  task t_disable;
    setsel(3'h3);
    wait_for(2, 1'b1, 80, n);
    k = 0;
    repeat (6500) begin
      @(negedge pclk);
      if (link.fault_level !== 1'b1) k++;
    end
    check(k, 0);
    apb(REG_STATUS, 1'b0, 32'h0, r, e);
    check(r[6:4], 3'h3);
    setsel(3'h4);
    wait_for(2, 1'b0, 80, n);
    wait_for(0, 1'b1, ST4 + 20, n);
    check(inr(n, ST4 - 24, ST4 + 6), 1'b1);
    $display("test disable done");
  endtask : t_disable
  task t_first_edge;
    setsel(3'h5);
    k = 0;
    do begin
      apb(REG_STATUS, 1'b0, 32'h0, r, e);
      k++;
    end while (!(r[2] === 1'b0 && r[6:4] === 3'h5) && k < 400);
    check(r[6:4], 3'h5);
    k = 0;
    repeat (1000) begin
      @(negedge pclk);
      if (wd_running !== 1'b0 || link.fault_level !== 1'b1) k++;
    end
    check(k, 0);
    tog();
    wait_for(0, 1'b1, 40, n);
    check(wd_running, 1'b1);
    $display("test first edge done");
  endtask : t_first_edge
  task t_glitch;
    wait_for(3, 1'b0, 200, n);
    wait_for(3, 1'b1, PW * DIV + 10, n);
    check(inr(n, PW - 3, PW + 3), 1'b1);
    pulses(8, 6, 8, k);
    check(k > 0, 1'b1);
    wait_for(3, 1'b1, PW * DIV + 10, n);
    pulses(12, 12, 15, k);
    check(k, 0);
    $display("test glitch done");
  endtask : t_glitch
  //////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    ctl_sel = 3'h0;
    bad_count = 0;
    n_tests = 0;
    link2.strobe_in = 1'b0;
    {link2.timing_sel_2, link2.timing_sel_1, link2.timing_sel_0} = 3'h4;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_sel();
    t_timeout();
    t_alive();
    t_change_in_fault();
    t_disable();
    t_first_edge();
    t_glitch();
    tally_and_finish();
  end
endmodule : pin_selectable_watchdog_tb
